/* File: core/rmsr_consts.vh */
// Shared constants for the monitoring select and readout pair
`ifndef RMSR_CONSTS_VH
`define RMSR_CONSTS_VH

// Register selector codes on the model register port
`define RMSR_SEL_EVTSEL 2'h0
`define RMSR_SEL_CTR    2'h1
`define RMSR_SEL_ASSOC  2'h2

// Select register fields
`define RMSR_EVT_MSB 7
`define RMSR_EVT_LSB 0
`define RMSR_TAG_MSB 41
`define RMSR_TAG_LSB 32

// Association register tag field
`define RMSR_ASSOC_TAG_MSB 9
`define RMSR_ASSOC_TAG_LSB 0

// Counter readout flag and data positions
`define RMSR_ERR_BIT  63
`define RMSR_UNAV_BIT 62
`define RMSR_OVF_BIT  61
`define RMSR_DATA_MSB 61

// Reserved bit masks, a set bit is reserved
`define RMSR_EVTSEL_RSVD 64'hffff_fc00_ffff_ff00
`define RMSR_ASSOC_RSVD  64'hffff_ffff_ffff_fc00

// Reset values
`define RMSR_EVTSEL_RST 64'h0000_0000_0000_0000
`define RMSR_ASSOC_RST  64'h0000_0000_0000_0000
`define RMSR_RDATA_RST  64'h0000_0000_0000_0000

// Event codes
`define RMSR_EVT_OCC    8'h01
`define RMSR_EVT_BW_TOT 8'h02
`define RMSR_EVT_BW_LOC 8'h03

// Sizes
`define RMSR_TAG_W    10
`define RMSR_IDX_W    6
`define RMSR_NUM_TAGS 64
`define RMSR_MAX_TAG  10'h03f
`define RMSR_CNT_W    24
`define RMSR_CNT_MAX  24'hff_ffff
`define RMSR_OVF_CAP  1'b1

`endif

/* File: core/rmsr_wr_check.v */
`timescale 1ns/1ps
`default_nettype none
`include "rmsr_consts.vh"

module rmsr_wr_check
(
  // Write candidate
  input  wire [63:0]              wdata,
  input  wire [63:0]              rsvd_mask,
  input  wire [`RMSR_TAG_W-1:0]   tag,
  // Verdict
  output wire                     fault
);

  // Stored reserved bits are always zero, so any set bit modifies one
  assign fault = (|(wdata & rsvd_mask)) | (tag > `RMSR_MAX_TAG);

endmodule
`default_nettype wire

/* File: core/rmsr_cnt_bank.v */
`timescale 1ns/1ps
`default_nettype none
`include "rmsr_consts.vh"

module rmsr_cnt_bank
#(
  parameter OVF_EN = 1
)
(
  // Clock and reset
  input  wire                     clk_sys,
  input  wire                     arst_n,
  // Count events
  input  wire                     inc,
  input  wire [`RMSR_IDX_W-1:0]   inc_tag,
  input  wire                     dec,
  input  wire [`RMSR_IDX_W-1:0]   dec_tag,
  // Readout
  input  wire [`RMSR_IDX_W-1:0]   rd_tag,
  input  wire                     ovf_clr,
  output wire [`RMSR_CNT_W-1:0]   cnt_out,
  output wire                     ovf_out
);

  wire [`RMSR_NUM_TAGS*`RMSR_CNT_W-1:0] cnt_flat;
  wire [`RMSR_NUM_TAGS-1:0]             ovf_flat;

  genvar i;
  generate
    for (i = 0; i < `RMSR_NUM_TAGS; i = i + 1)
    begin : g_tag
      reg  [`RMSR_CNT_W-1:0] cnt_reg;
      reg                    ovf_reg;
      wire                   hit_i;
      wire                   hit_d;
      wire                   wrap;
      assign hit_i = inc & (inc_tag == i[`RMSR_IDX_W-1:0]);
      assign hit_d = dec & (dec_tag == i[`RMSR_IDX_W-1:0]);
      assign wrap  = hit_i & ~hit_d & (cnt_reg == `RMSR_CNT_MAX);
      // Counter wraps silently; the flag is the only trace of it
      always @(posedge clk_sys or negedge arst_n)
      begin
        if (!arst_n)
          cnt_reg <= {`RMSR_CNT_W{1'b0}};
        else if (hit_i && !hit_d)
          cnt_reg <= cnt_reg + 1'b1;
        else if (hit_d && !hit_i && cnt_reg != {`RMSR_CNT_W{1'b0}})
          cnt_reg <= cnt_reg - 1'b1;
      end
      // Wrap wins over a clear arriving in the same cycle
      always @(posedge clk_sys or negedge arst_n)
      begin
        if (!arst_n)
          ovf_reg <= 1'b0;
        else if (wrap && OVF_EN != 0)
          ovf_reg <= 1'b1;
        else if (ovf_clr && rd_tag == i[`RMSR_IDX_W-1:0])
          ovf_reg <= 1'b0;
      end
      assign cnt_flat[i*`RMSR_CNT_W +: `RMSR_CNT_W] = cnt_reg;
      assign ovf_flat[i] = ovf_reg;
    end
  endgenerate

  // Readout of the selected tag
  assign cnt_out = cnt_flat[rd_tag*`RMSR_CNT_W +: `RMSR_CNT_W];
  assign ovf_out = ovf_flat[rd_tag];

endmodule
`default_nettype wire

/* File: core/rmsr_top.v */
// What this block does
// - Select holds event code 7:0, tag 41:32
// - Data reported per tag, for selected tag
// - Unsupported tag or event sets bit 63
// - Unavailable data sets bit 62
// - Data valid only when 63 and 62 clear
// - Bit 61 flags bandwidth counter wrap, cleared by read
// - No interrupts; software samples explicitly
// - Independent from performance counter registers
// - Data field up to 61 bits wide, bits 60:0
// - Bandwidth counters 24 bits, wrap on overflow
// - Select and association writable at any time
// - Reserved bit change gives protection fault
// - Tag above maximum gives protection fault
// - Association and counters survive management interrupt
// - Codes 01,02,03 supported; others unsupported
`timescale 1ns/1ps
`default_nettype none
`include "rmsr_consts.vh"

module rmsr_top
(
  // Clock and reset
  input  wire                     clk_sys,
  input  wire                     arst_n,
  // Model register read and write port
  input  wire                     reg_wr,
  input  wire                     reg_rd,
  input  wire [1:0]               reg_sel,
  input  wire [63:0]              reg_wdata,
  output wire [63:0]              reg_rdata,
  output wire                     reg_done,
  output wire                     reg_fault,
  // Monitored events from the cache side
  input  wire                     bw_total_evt,
  input  wire                     bw_local_evt,
  input  wire                     occ_fill_evt,
  input  wire                     occ_evict_evt,
  input  wire [`RMSR_TAG_W-1:0]   occ_evict_tag,
  // Active tag used to label internal operations
  output wire [`RMSR_TAG_W-1:0]   active_tag
);

  // Architectural state
  reg  [63:0]                evtsel_reg;
  reg  [63:0]                evtsel_next;
  reg  [63:0]                assoc_reg;
  reg  [63:0]                assoc_next;
  reg  [`RMSR_NUM_TAGS-1:0]  seen_reg;
  reg  [`RMSR_NUM_TAGS-1:0]  seen_next;
  // Response state
  reg  [63:0]                rdata_reg;
  reg  [63:0]                rdata_next;
  reg                        done_reg;
  reg                        done_next;
  reg                        fault_reg;
  reg                        fault_next;

  // Decoded selection
  wire [7:0]                 sel_evt;
  wire [`RMSR_TAG_W-1:0]     sel_tag;
  wire [`RMSR_IDX_W-1:0]     sel_idx;
  wire [`RMSR_IDX_W-1:0]     act_idx;
  wire [`RMSR_IDX_W-1:0]     evict_idx;
  wire                       evt_occ;
  wire                       evt_tot;
  wire                       evt_loc;
  wire                       evt_ok;
  wire                       tag_ok;
  wire                       sel_err;
  wire                       sel_unav;

  // Bank outputs
  wire [`RMSR_CNT_W-1:0]     occ_cnt;
  wire [`RMSR_CNT_W-1:0]     tot_cnt;
  wire [`RMSR_CNT_W-1:0]     loc_cnt;
  wire                       tot_ovf;
  wire                       loc_ovf;
  wire                       occ_ovf_unused;
  reg  [`RMSR_CNT_W-1:0]     sel_cnt;
  reg                        sel_ovf;

  // Access decode
  wire                       acc_wr;
  wire                       acc_rd;
  wire                       ctr_rd;
  wire                       evtsel_bad;
  wire                       assoc_bad;
  wire [63:0]                ctr_word;

  // Writes take precedence if both strobes arrive together
  assign acc_wr = reg_wr;
  assign acc_rd = reg_rd & ~reg_wr;
  assign ctr_rd = acc_rd & (reg_sel == `RMSR_SEL_CTR);

  // Field extraction from the select register
  assign sel_evt = evtsel_reg[`RMSR_EVT_MSB:`RMSR_EVT_LSB];
  assign sel_tag = evtsel_reg[`RMSR_TAG_MSB:`RMSR_TAG_LSB];
  assign sel_idx = sel_tag[`RMSR_IDX_W-1:0];
  assign act_idx = assoc_reg[`RMSR_IDX_W-1:0];
  assign evict_idx = occ_evict_tag[`RMSR_IDX_W-1:0];
  assign active_tag = assoc_reg[`RMSR_ASSOC_TAG_MSB:`RMSR_ASSOC_TAG_LSB];

  // Event code decode; everything outside the three codes is reserved
  assign evt_occ = (sel_evt == `RMSR_EVT_OCC);
  assign evt_tot = (sel_evt == `RMSR_EVT_BW_TOT);
  assign evt_loc = (sel_evt == `RMSR_EVT_BW_LOC);
  assign evt_ok  = evt_occ | evt_tot | evt_loc;
  assign tag_ok  = (sel_tag <= `RMSR_MAX_TAG);

  // Error outranks unavailable so the two never show together
  assign sel_err  = ~evt_ok | ~tag_ok;
  assign sel_unav = ~sel_err & ~seen_reg[sel_idx];

  // Write checks for the two writable registers
  rmsr_wr_check u_chk_evtsel
  (
    .wdata     (reg_wdata),
    .rsvd_mask (`RMSR_EVTSEL_RSVD),
    .tag       (reg_wdata[`RMSR_TAG_MSB:`RMSR_TAG_LSB]),
    .fault     (evtsel_bad)
  );

  rmsr_wr_check u_chk_assoc
  (
    .wdata     (reg_wdata),
    .rsvd_mask (`RMSR_ASSOC_RSVD),
    .tag       (reg_wdata[`RMSR_ASSOC_TAG_MSB:`RMSR_ASSOC_TAG_LSB]),
    .fault     (assoc_bad)
  );

  // Occupancy grows with fills by the active tag, shrinks on eviction
  rmsr_cnt_bank #(.OVF_EN(0)) u_occ
  (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .inc     (occ_fill_evt),
    .inc_tag (act_idx),
    .dec     (occ_evict_evt),
    .dec_tag (evict_idx),
    .rd_tag  (sel_idx),
    .ovf_clr (1'b0),
    .cnt_out (occ_cnt),
    .ovf_out (occ_ovf_unused)
  );

  // Total external bandwidth, 24-bit wrapping counters per tag
  rmsr_cnt_bank #(.OVF_EN(1)) u_tot
  (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .inc     (bw_total_evt),
    .inc_tag (act_idx),
    .dec     (1'b0),
    .dec_tag (act_idx),
    .rd_tag  (sel_idx),
    .ovf_clr (ctr_rd & evt_tot & ~sel_err),
    .cnt_out (tot_cnt),
    .ovf_out (tot_ovf)
  );

  // Local external bandwidth, same shape as the total bank
  rmsr_cnt_bank #(.OVF_EN(1)) u_loc
  (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .inc     (bw_local_evt),
    .inc_tag (act_idx),
    .dec     (1'b0),
    .dec_tag (act_idx),
    .rd_tag  (sel_idx),
    .ovf_clr (ctr_rd & evt_loc & ~sel_err),
    .cnt_out (loc_cnt),
    .ovf_out (loc_ovf)
  );

  // Pick the bank matching the selected event code
  always @*
  begin
    sel_cnt = {`RMSR_CNT_W{1'b0}};
    sel_ovf = 1'b0;
    if (evt_occ)
      sel_cnt = occ_cnt;
    else if (evt_tot)
    begin
      sel_cnt = tot_cnt;
      sel_ovf = tot_ovf & `RMSR_OVF_CAP;
    end
    else if (evt_loc)
    begin
      sel_cnt = loc_cnt;
      sel_ovf = loc_ovf & `RMSR_OVF_CAP;
    end
  end

  // Readout word; data and overflow are zeroed whenever a flag is up
  assign ctr_word = {sel_err,
                     sel_unav,
                     sel_ovf & ~sel_err & ~sel_unav,
                     {(`RMSR_DATA_MSB-`RMSR_CNT_W){1'b0}},
                     sel_cnt & {`RMSR_CNT_W{~sel_err & ~sel_unav}}};

  // Register port: accepted in any cycle, no quiescent state needed
  always @*
  begin
    evtsel_next = evtsel_reg;
    assoc_next  = assoc_reg;
    seen_next   = seen_reg;
    rdata_next  = rdata_reg;
    done_next   = acc_wr | acc_rd;
    fault_next  = 1'b0;
    if (acc_wr)
    begin
      case (reg_sel)
        `RMSR_SEL_EVTSEL:
          if (evtsel_bad)
            fault_next = 1'b1;
          else
            evtsel_next = reg_wdata;
        `RMSR_SEL_ASSOC:
          if (assoc_bad)
            fault_next = 1'b1;
          else
          begin
            assoc_next = reg_wdata;
            seen_next[reg_wdata[`RMSR_IDX_W-1:0]] = 1'b1;
          end
        default:
          fault_next = 1'b1;   // Counter readout is read-only
      endcase
    end
    else if (acc_rd)
    begin
      case (reg_sel)
        `RMSR_SEL_EVTSEL: rdata_next = evtsel_reg;
        `RMSR_SEL_ASSOC:  rdata_next = assoc_reg;
        `RMSR_SEL_CTR:    rdata_next = ctr_word;
        default:          fault_next = 1'b1;
      endcase
    end
  end

  // State has no clear path other than reset, so a management
  // interrupt leaves association and counters as they were
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      evtsel_reg <= `RMSR_EVTSEL_RST;
      assoc_reg  <= `RMSR_ASSOC_RST;
      seen_reg   <= {`RMSR_NUM_TAGS{1'b0}};
    end
    else
    begin
      evtsel_reg <= evtsel_next;
      assoc_reg  <= assoc_next;
      seen_reg   <= seen_next;
    end
  end

  // Response registers; data holds until the next read
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_reg <= `RMSR_RDATA_RST;
      done_reg  <= 1'b0;
      fault_reg <= 1'b0;
    end
    else
    begin
      rdata_reg <= rdata_next;
      done_reg  <= done_next;
      fault_reg <= fault_next;
    end
  end

  // Only sampled results leave the block: no interrupt and no
  // count trigger, and nothing here touches performance counters
  assign reg_rdata = rdata_reg;
  assign reg_done  = done_reg;
  assign reg_fault = fault_reg;

endmodule
`default_nettype wire

/* File: bench/rmsr_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rmsr_consts.vh"

module rmsr_chk
(
  // Clock and reset
  input wire logic                   clk_sys,
  input wire logic                   arst_n,
  // Register port
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [1:0]             reg_sel,
  input wire logic [63:0]            reg_wdata,
  input wire logic [63:0]            reg_rdata,
  input wire logic                   reg_done,
  input wire logic                   reg_fault,
  // Cache side events
  input wire logic                   bw_total_evt,
  input wire logic                   bw_local_evt,
  input wire logic                   occ_fill_evt,
  input wire logic                   occ_evict_evt,
  input wire logic [`RMSR_TAG_W-1:0] occ_evict_tag,
  input wire logic [`RMSR_TAG_W-1:0] active_tag
);
  // All checks share the core clock and its reset
  default clocking dck @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  a_access_done: assert property ((reg_wr || reg_rd) |=> reg_done)
    else $error("access without completion");
  a_done_cause: assert property (reg_done |-> $past(reg_wr || reg_rd))
    else $error("completion without access");
  a_fault_pair: assert property (reg_fault |-> reg_done)
    else $error("fault outside completion");
  a_sel_rsvd: assert property ((reg_wr && reg_sel == `RMSR_SEL_EVTSEL
    && |(reg_wdata & `RMSR_EVTSEL_RSVD)) |=> reg_fault)
    else $error("reserved select bit accepted");
  a_sel_tag: assert property ((reg_wr && reg_sel == `RMSR_SEL_EVTSEL
    && reg_wdata[41:32] > `RMSR_MAX_TAG) |=> reg_fault)
    else $error("oversized select tag accepted");
  a_assoc_rsvd: assert property ((reg_wr && reg_sel == `RMSR_SEL_ASSOC
    && |(reg_wdata & `RMSR_ASSOC_RSVD)) |=> reg_fault)
    else $error("reserved association bit accepted");
  a_sel_good: assert property ((reg_wr && reg_sel == `RMSR_SEL_EVTSEL
    && (reg_wdata & `RMSR_EVTSEL_RSVD) == 64'h0 && reg_wdata[41:38] == 4'h0)
    |=> !reg_fault)
    else $error("legal select write refused");
  a_assoc_take: assert property ((reg_wr && reg_sel == `RMSR_SEL_ASSOC
    && reg_wdata[63:6] == 58'h0)
    |=> !reg_fault && {54'h0, active_tag} == $past(reg_wdata))
    else $error("legal association write not taken");
  a_tag_hold: assert property (!(reg_wr && reg_sel == `RMSR_SEL_ASSOC)
    |=> $stable(active_tag))
    else $error("active tag moved without write");
  a_flag_clear: assert property ((reg_rdata[63] || reg_rdata[62])
    |-> reg_rdata[61:0] == 62'h0)
    else $error("data present beside error flags");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
endmodule

bind rmsr_top rmsr_chk u_rmsr_chk
(
  .clk_sys(clk_sys), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_done(reg_done), .reg_fault(reg_fault), .bw_total_evt(bw_total_evt),
  .bw_local_evt(bw_local_evt), .occ_fill_evt(occ_fill_evt),
  .occ_evict_evt(occ_evict_evt), .occ_evict_tag(occ_evict_tag),
  .active_tag(active_tag)
);

`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rmsr_consts.vh"

module tb_top;
  logic        clk_sys;
  logic        arst_n;
  logic        reg_wr;
  logic        reg_rd;
  logic [1:0]  reg_sel;
  logic [63:0] reg_wdata;
  wire  [63:0] reg_rdata;
  wire         reg_done;
  wire         reg_fault;
  logic [3:0]  evts;
  logic [9:0]  occ_evict_tag;
  wire  [9:0]  active_tag;
  int          errors;
  int          samples_checked;
  localparam logic [63:0] ERR  = 64'h8000_0000_0000_0000;
  localparam logic [63:0] UNAV = 64'h4000_0000_0000_0000;

  rmsr_top u_rmsr_top
  (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_done(reg_done), .reg_fault(reg_fault), .bw_total_evt(evts[0]),
    .bw_local_evt(evts[1]), .occ_fill_evt(evts[2]),
    .occ_evict_evt(evts[3]), .occ_evict_tag(occ_evict_tag),
    .active_tag(active_tag)
  );

  // Free running 25 MHz core clock
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [63:0] seen,
                     input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // One register access; strobe dropped after the taking edge
  task automatic acc(input string nm, input logic w, input logic [1:0] s,
                     input logic [63:0] d, input logic f,
                     input logic [63:0] e);
    @(posedge clk_sys);
    reg_wr <= w;
    reg_rd <= !w;
    reg_sel <= s;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    chk({nm, " done"}, {63'h0, reg_done}, 64'h1);
    chk({nm, " fault"}, {63'h0, reg_fault}, {63'h0, f});
    if (!w)
      chk(nm, reg_rdata, e);
  endtask

  task automatic wsel(input logic [9:0] tag, input logic [7:0] code);
    acc("sel wr", 1'b1, `RMSR_SEL_EVTSEL, {22'h0, tag, 24'h0, code}, 1'b0, 0);
  endtask

  // Pulses of one event kind, spaced so each lands on its own edge
  task automatic pulse(input int n, input logic [3:0] which,
                       input logic [9:0] etag);
    repeat (n)
    begin
      @(posedge clk_sys);
      evts <= which;
      occ_evict_tag <= etag;
      @(posedge clk_sys);
      evts <= 4'h0;
    end
  endtask

  task automatic s_reset();
    acc("sel rst", 1'b0, `RMSR_SEL_EVTSEL, 0, 1'b0, 64'h0);
    acc("assoc rst", 1'b0, `RMSR_SEL_ASSOC, 0, 1'b0, 64'h0);
    acc("ctr rst", 1'b0, `RMSR_SEL_CTR, 0, 1'b0, ERR);
  endtask

  // Refused writes leave state and read data alone
  task automatic s_faults();
    acc("sel b8", 1'b1, `RMSR_SEL_EVTSEL, 64'h100, 1'b1, 0);
    acc("sel b42", 1'b1, `RMSR_SEL_EVTSEL, 64'h400_0000_0000, 1'b1, 0);
    acc("sel t64", 1'b1, `RMSR_SEL_EVTSEL, 64'h40_0000_0001, 1'b1, 0);
    acc("as b10", 1'b1, `RMSR_SEL_ASSOC, 64'h400, 1'b1, 0);
    acc("as t64", 1'b1, `RMSR_SEL_ASSOC, 64'h40, 1'b1, 0);
    acc("ctr wr", 1'b1, `RMSR_SEL_CTR, 64'h1, 1'b1, 0);
    acc("unmapped", 1'b0, 2'h3, 0, 1'b1, ERR);
    acc("sel kept", 1'b0, `RMSR_SEL_EVTSEL, 0, 1'b0, 64'h0);
  endtask

  // Five codes, three supported and two not, on a tag that was never associated
  task automatic s_codes();
    logic [7:0] codes [5];
    codes = '{8'h01, 8'h02, 8'h03, 8'h04, 8'hff};
    foreach (codes[i])
    begin
      wsel(10'h5, codes[i]);
      acc("code", 1'b0, `RMSR_SEL_CTR, 0, 1'b0, (i < 3) ? UNAV : ERR);
    end
  endtask

  task automatic s_counts();
    acc("as5", 1'b1, `RMSR_SEL_ASSOC, 64'h5, 1'b0, 0);
    chk("active", {54'h0, active_tag}, 64'h5);
    pulse(3, 4'b0001, 10'h0);
    pulse(2, 4'b0010, 10'h0);
    pulse(4, 4'b0100, 10'h0);
    pulse(1, 4'b1000, 10'h5);
    wsel(10'h5, `RMSR_EVT_BW_TOT);
    acc("tot", 1'b0, `RMSR_SEL_CTR, 0, 1'b0, 64'h3);
    wsel(10'h5, `RMSR_EVT_BW_LOC);
    acc("loc", 1'b0, `RMSR_SEL_CTR, 0, 1'b0, 64'h2);
    wsel(10'h5, `RMSR_EVT_OCC);
    acc("occ", 1'b0, `RMSR_SEL_CTR, 0, 1'b0, 64'h3);
    acc("selrd", 1'b0, `RMSR_SEL_EVTSEL, 0, 1'b0, 64'h5_0000_0001);
    acc("as63", 1'b1, `RMSR_SEL_ASSOC, 64'h3f, 1'b0, 0);
    pulse(1, 4'b0001, 10'h0);
    wsel(10'h5, `RMSR_EVT_BW_TOT);
    acc("tot5", 1'b0, `RMSR_SEL_CTR, 0, 1'b0, 64'h3);
    wsel(10'h3f, `RMSR_EVT_BW_TOT);
    acc("tot63", 1'b0, `RMSR_SEL_CTR, 0, 1'b0, 64'h1);
    wsel(10'h6, `RMSR_EVT_BW_TOT);
    acc("tot6", 1'b0, `RMSR_SEL_CTR, 0, 1'b0, UNAV);
  endtask

  task automatic complete_run();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence after a 12 cycle reset
  initial
  begin
    errors = 0;
    samples_checked = 0;
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_sel = 2'h0;
    reg_wdata = 64'h0;
    evts = 4'h0;
    occ_evict_tag = 10'h0;
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    s_reset();
    s_faults();
    s_codes();
    s_counts();
    complete_run();
  end

  // Watchdog well past the hundred or so cycles the run needs
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    complete_run();
  end
endmodule

`default_nettype wire
